// file: hw/iep_irq_ctrl.sv
/*
 * interrupt enable, priority and external interrupt flag logic.
 * assumes a cpu core that acknowledges the offered vector, signals
 * return from service, and gives a machine-cycle tick.
 */
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "iep_map.svh"
module iep_irq_ctrl (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic [7:0]      sfr_rdata,
    // core side
    input  wire logic [7:0] core_irq_enable,
    input  wire logic       mc_tick,
    input  wire logic       irq_ack,
    input  wire logic       irq_return,
    output logic            irq_req,
    output logic [3:0]      irq_vector,
    output logic [1:0]      irq_level,
    // external interrupt pins
    input  wire logic       extint0_pin,
    input  wire logic       extint1_pin,
    input  wire logic       extint2_pin,
    input  wire logic       extint3_pin,
    // peripheral sources
    input  wire logic       timer0_overflow_set,
    input  wire logic       timer1_overflow_set,
    input  wire logic       timer2_irq_flag,
    input  wire logic       serial_irq_flag,
    input  wire logic       brownout_detected_flag,
    input  wire logic       wake_timer_overflow_flag,
    input  wire logic       spi_transfer_done_flag,
    input  wire logic       spi_overrun_flag,
    input  wire logic       spi_mode_fault_flag,
    // timer run controls
    output logic            timer0_run,
    output logic            timer1_run
);
    // registers
    logic [7:0]  tmr_cfg_ff;
    logic [1:0]  tmr_flag_ff;
    logic [5:0]  prio_lo_ff;
    logic [7:0]  prio_hi_ff;
    logic [2:0]  xprio_lo_ff;
    logic [2:0]  xprio_hi_ff;
    logic [2:0]  xen_ff;
    logic [7:0]  x23_cfg_ff;
    logic [3:0]  insvc_ff;
    logic        irq_req_ff;
    logic [3:0]  irq_vector_ff;
    logic [1:0]  irq_level_ff;
    logic [7:0]  sfr_rdata_ff;
    // next values
    logic [1:0]  nxt_tmr_flag;
    logic [3:0]  nxt_insvc;
    logic        nxt_irq_req;
    logic [7:0]  nxt_rdata;
    // decode
    wire  sel_tmr   = sfr_addr == `IEP_ADR_TMR_CTL;
    wire  sel_plo   = sfr_addr == `IEP_ADR_PRIO_LO;
    wire  sel_phi   = sfr_addr == `IEP_ADR_PRIO_HI;
    wire  sel_xphi  = sfr_addr == `IEP_ADR_XPRIO_HI;
    wire  sel_xplo  = sfr_addr == `IEP_ADR_XPRIO_LO;
    wire  sel_xen   = sfr_addr == `IEP_ADR_XEN;
    wire  sel_x23   = sfr_addr == `IEP_ADR_X23_CTL;
    wire  wr_tmr    = sfr_wr & sel_tmr;
    wire  wr_plo    = sfr_wr & sel_plo;
    wire  wr_phi    = sfr_wr & sel_phi;
    wire  wr_xphi   = sfr_wr & sel_xphi;
    wire  wr_xplo   = sfr_wr & sel_xplo;
    wire  wr_xen    = sfr_wr & sel_xen;
    wire  wr_x23    = sfr_wr & sel_x23;
    // service entry clears the matching timer or edge-type external flag
    logic [10:0] svc_hit;
    assign svc_hit = irq_ack ? (11'h001 << irq_vector_ff) : 11'h000;
    // external interrupt flags
    logic        x0_flag;
    logic        x1_flag;
    logic        x2_flag;
    logic        x3_flag;
    iep_extint u_x0 (
        .clk        (clk),
        .resetn     (resetn),
        .pin        (extint0_pin),
        .mc_tick    (mc_tick),
        .edge_mode  (tmr_cfg_ff[`IEP_B_X0_TYPE]),
        .flag_wr    (wr_tmr),
        .flag_wdata (sfr_wdata[`IEP_B_X0_FLAG]),
        .svc_clr    (svc_hit[iep_pkg::IEP_V_X0]),
        .flag       (x0_flag)
    );
    iep_extint u_x1 (
        .clk        (clk),
        .resetn     (resetn),
        .pin        (extint1_pin),
        .mc_tick    (mc_tick),
        .edge_mode  (tmr_cfg_ff[`IEP_B_X1_TYPE]),
        .flag_wr    (wr_tmr),
        .flag_wdata (sfr_wdata[`IEP_B_X1_FLAG]),
        .svc_clr    (svc_hit[iep_pkg::IEP_V_X1]),
        .flag       (x1_flag)
    );
    iep_extint u_x2 (
        .clk        (clk),
        .resetn     (resetn),
        .pin        (extint2_pin),
        .mc_tick    (mc_tick),
        .edge_mode  (x23_cfg_ff[`IEP_B_X2_TYPE]),
        .flag_wr    (wr_x23),
        .flag_wdata (sfr_wdata[`IEP_B_X2_FLAG]),
        .svc_clr    (svc_hit[iep_pkg::IEP_V_X2]),
        .flag       (x2_flag)
    );
    iep_extint u_x3 (
        .clk        (clk),
        .resetn     (resetn),
        .pin        (extint3_pin),
        .mc_tick    (mc_tick),
        .edge_mode  (x23_cfg_ff[`IEP_B_X3_TYPE]),
        .flag_wr    (wr_x23),
        .flag_wdata (sfr_wdata[`IEP_B_X3_FLAG]),
        .svc_clr    (svc_hit[iep_pkg::IEP_V_X3]),
        .flag       (x3_flag)
    );
    // timer overflow flags, set wins
    assign nxt_tmr_flag[0] = timer0_overflow_set |
        (wr_tmr ? sfr_wdata[`IEP_B_TF0] :
         (svc_hit[iep_pkg::IEP_V_T0] ? 1'b0 : tmr_flag_ff[0]));
    assign nxt_tmr_flag[1] = timer1_overflow_set |
        (wr_tmr ? sfr_wdata[`IEP_B_TF1] :
         (svc_hit[iep_pkg::IEP_V_T1] ? 1'b0 : tmr_flag_ff[1]));
    // source requests in vector order
    wire spi_any = spi_transfer_done_flag | spi_overrun_flag |
                   spi_mode_fault_flag;
    logic [10:0] src_raw;
    logic [10:0] src_en;
    logic [10:0] src_req;
    assign src_raw = {brownout_detected_flag, wake_timer_overflow_flag,
                      spi_any, x3_flag, x2_flag, timer2_irq_flag,
                      serial_irq_flag, tmr_flag_ff[1], x1_flag,
                      tmr_flag_ff[0], x0_flag};
    assign src_en = {xen_ff[`IEP_B_BOD],
                     xen_ff[`IEP_B_WAKE],
                     xen_ff[`IEP_B_SPI],
                     x23_cfg_ff[`IEP_B_X3_EN],
                     x23_cfg_ff[`IEP_B_X2_EN],
                     core_irq_enable[5:0]} &
                    {11{core_irq_enable[`IEP_B_GLOBAL_EN]}};
    assign src_req = src_raw & src_en;
    // two-bit level per source, high bit above low bit
    logic [21:0] src_lvl;
    assign src_lvl = {
        xprio_hi_ff[`IEP_B_BOD],  xprio_lo_ff[`IEP_B_BOD],
        xprio_hi_ff[`IEP_B_WAKE], xprio_lo_ff[`IEP_B_WAKE],
        xprio_hi_ff[`IEP_B_SPI],  xprio_lo_ff[`IEP_B_SPI],
        prio_hi_ff[7], x23_cfg_ff[`IEP_B_X3_PLO],
        prio_hi_ff[6], x23_cfg_ff[`IEP_B_X2_PLO],
        prio_hi_ff[5], prio_lo_ff[5],
        prio_hi_ff[4], prio_lo_ff[4],
        prio_hi_ff[3], prio_lo_ff[3],
        prio_hi_ff[2], prio_lo_ff[2],
        prio_hi_ff[1], prio_lo_ff[1],
        prio_hi_ff[0], prio_lo_ff[0]};
    // arbitration
    logic        arb_found;
    logic [3:0]  arb_vec;
    iep_pkg::iep_level_t arb_lvl;
    iep_arbiter u_arb (
        .req      (src_req),
        .lvl      (src_lvl),
        .found    (arb_found),
        .best_vec (arb_vec),
        .best_lvl (arb_lvl)
    );
    // in-service levels and preemption
    wire insvc_any = |insvc_ff;
    iep_pkg::iep_level_t cur_lvl;
    assign cur_lvl = insvc_ff[3] ? 2'h3 :
                     insvc_ff[2] ? 2'h2 :
                     insvc_ff[1] ? 2'h1 : 2'h0;
    wire [3:0] top_oh = insvc_any ? (4'h1 << cur_lvl) : 4'h0;
    wire [3:0] ack_oh = irq_ack ? (4'h1 << irq_level_ff) : 4'h0;
    assign nxt_insvc = (irq_return ? (insvc_ff & ~top_oh) : insvc_ff) |
                       ack_oh;
    wire preempt_ok = !insvc_any || (arb_lvl > cur_lvl);
    assign nxt_irq_req = arb_found && preempt_ok && !irq_ack;
    // read mux, reserved bits zero
    wire [7:0] rd_tmr = tmr_cfg_ff |
        {tmr_flag_ff[1], 1'b0, tmr_flag_ff[0], 1'b0,
         x1_flag, 1'b0, x0_flag, 1'b0};
    wire [7:0] rd_x23 = x23_cfg_ff |
        {2'b00, x3_flag, 3'b000, x2_flag, 1'b0};
    assign nxt_rdata = !sfr_rd  ? 8'h00 :
                       sel_tmr  ? rd_tmr :
                       sel_plo  ? {2'b00, prio_lo_ff} :
                       sel_phi  ? prio_hi_ff :
                       sel_xphi ? {5'h00, xprio_hi_ff} :
                       sel_xplo ? {5'h00, xprio_lo_ff} :
                       sel_xen  ? {5'h00, xen_ff} :
                       sel_x23  ? rd_x23 : 8'h00;
    // configuration registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tmr_cfg_ff <= `IEP_RST_REG;
            x23_cfg_ff <= `IEP_RST_REG;
        end else begin
            if (wr_tmr) begin
                tmr_cfg_ff <= sfr_wdata & `IEP_MSK_TMR_CFG;
            end
            if (wr_x23) begin
                x23_cfg_ff <= sfr_wdata & `IEP_MSK_X23_CFG;
            end
        end
    end
    // priority registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prio_lo_ff <= 6'h00;
            prio_hi_ff <= `IEP_RST_REG;
        end else begin
            if (wr_plo) begin
                prio_lo_ff <= sfr_wdata[5:0];
            end
            if (wr_phi) begin
                prio_hi_ff <= sfr_wdata;
            end
        end
    end
    // extended enable and priority registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xprio_lo_ff <= 3'h0;
            xprio_hi_ff <= 3'h0;
            xen_ff      <= 3'h0;
        end else begin
            if (wr_xplo) begin
                xprio_lo_ff <= sfr_wdata[2:0];
            end
            if (wr_xphi) begin
                xprio_hi_ff <= sfr_wdata[2:0];
            end
            if (wr_xen) begin
                xen_ff <= sfr_wdata[2:0];
            end
        end
    end
    // flags, service state, outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tmr_flag_ff   <= 2'h0;
            insvc_ff      <= 4'h0;
            irq_req_ff    <= 1'b0;
            irq_vector_ff <= 4'h0;
            irq_level_ff  <= 2'h0;
            sfr_rdata_ff  <= 8'h00;
        end else begin
            tmr_flag_ff   <= nxt_tmr_flag;
            insvc_ff      <= nxt_insvc;
            irq_req_ff    <= nxt_irq_req;
            irq_vector_ff <= arb_vec;
            irq_level_ff  <= arb_lvl;
            sfr_rdata_ff  <= nxt_rdata;
        end
    end
    assign sfr_rdata  = sfr_rdata_ff;
    assign irq_req    = irq_req_ff;
    assign irq_vector = irq_vector_ff;
    assign irq_level  = irq_level_ff;
    assign timer0_run = tmr_cfg_ff[4];
    assign timer1_run = tmr_cfg_ff[6];
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_BOD_GATE: assert property (
        irq_req && irq_vector == 4'ha |-> $past(xen_ff[2]))
        else $error("brown-out request while masked");
    AST_WAKE_GATE: assert property (
        irq_req && irq_vector == 4'h9 |-> $past(xen_ff[1]))
        else $error("wake timer request while masked");
    AST_SPI_GATE: assert property (
        irq_req && irq_vector == 4'h8 |-> $past(xen_ff[0] && spi_any))
        else $error("spi request without enable or flag");
    AST_X0_LEVEL: assert property (
        irq_req && irq_vector == 4'h0 |->
        irq_level == $past({prio_hi_ff[0], prio_lo_ff[0]}))
        else $error("ext0 level mismatch");
    AST_X2_LEVEL: assert property (
        irq_req && irq_vector == 4'h6 |->
        irq_level == $past({prio_hi_ff[6], x23_cfg_ff[3]}))
        else $error("ext2 level mismatch");
    AST_BOD_LEVEL: assert property (
        irq_req && irq_vector == 4'ha |->
        irq_level == $past({xprio_hi_ff[2], xprio_lo_ff[2]}))
        else $error("brown-out level mismatch");
    AST_PREEMPT: assert property (
        irq_req |-> !$past(insvc_any) || irq_level > $past(cur_lvl))
        else $error("request not above in-service level");
    AST_ACK_DROP: assert property (
        irq_ack |=> !irq_req)
        else $error("request held after acknowledge");
    AST_RSV_ZERO: assert property (
        sfr_rd && sfr_addr == 8'hbd |=> sfr_rdata[7:3] == 5'h00)
        else $error("reserved bits not zero");
    sequence s_rd_idle;
        !sfr_rd ##1 1'b1;
    endsequence
    AST_RD_ONCE: assert property (
        s_rd_idle |-> sfr_rdata == 8'h00)
        else $error("read data outside answer cycle");
endmodule : iep_irq_ctrl

// file: hw/iep_map.svh
/*
 * register offsets, field positions, masks and reset values of the
 * interrupt enable / priority / external interrupt block.
 * assumes an 8-bit special-function register space.
 */
`ifndef IEP_MAP_SVH
`define IEP_MAP_SVH
// register offsets
`define IEP_ADR_TMR_CTL  8'h88
`define IEP_ADR_PRIO_LO  8'hb8
`define IEP_ADR_PRIO_HI  8'hba
`define IEP_ADR_XPRIO_HI 8'hbb
`define IEP_ADR_XPRIO_LO 8'hbc
`define IEP_ADR_XEN      8'hbd
`define IEP_ADR_X23_CTL  8'hc0
// reset value and writable masks
`define IEP_RST_REG      8'h00
`define IEP_MSK_PRIO_LO  8'h3f
`define IEP_MSK_XREG     8'h07
`define IEP_MSK_TMR_CFG  8'h55
`define IEP_MSK_X23_CFG  8'hdd
// timer and extint control fields
`define IEP_B_TF1        7
`define IEP_B_TF0        5
`define IEP_B_X1_FLAG    3
`define IEP_B_X1_TYPE    2
`define IEP_B_X0_FLAG    1
`define IEP_B_X0_TYPE    0
// extint 2/3 control fields
`define IEP_B_X3_PLO     7
`define IEP_B_X3_EN      6
`define IEP_B_X3_FLAG    5
`define IEP_B_X3_TYPE    4
`define IEP_B_X2_PLO     3
`define IEP_B_X2_EN      2
`define IEP_B_X2_FLAG    1
`define IEP_B_X2_TYPE    0
// extended enable / priority fields
`define IEP_B_BOD        2
`define IEP_B_WAKE       1
`define IEP_B_SPI        0
// core enable input fields
`define IEP_B_GLOBAL_EN  7
// number of sources
`define IEP_NSRC         11
`endif

// file: hw/iep_pkg.sv
/*
 * types of the interrupt enable / priority block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package iep_pkg;
    typedef logic [1:0] iep_level_t;
    typedef enum logic [3:0] {
        IEP_V_X0   = 4'h0,
        IEP_V_T0   = 4'h1,
        IEP_V_X1   = 4'h2,
        IEP_V_T1   = 4'h3,
        IEP_V_SER  = 4'h4,
        IEP_V_T2   = 4'h5,
        IEP_V_X2   = 4'h6,
        IEP_V_X3   = 4'h7,
        IEP_V_SPI  = 4'h8,
        IEP_V_WAKE = 4'h9,
        IEP_V_BOD  = 4'ha
    } iep_vec_t;
endpackage : iep_pkg

// file: hw/iep_extint.sv
/*
 * one external interrupt request flag, edge or level type.
 * assumes pin synchronous to clk and a one-cycle machine tick.
 */
`timescale 1ns/1ps
module iep_extint (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // pin and mode
    input  wire logic pin,
    input  wire logic mc_tick,
    input  wire logic edge_mode,
    // software and service
    input  wire logic flag_wr,
    input  wire logic flag_wdata,
    input  wire logic svc_clr,
    output logic      flag
);
    logic sample_ff;
    logic flag_ff;
    logic nxt_flag;
    wire  fall = mc_tick & sample_ff & ~pin;
    // set wins over any clear
    assign nxt_flag = edge_mode ?
        (fall | (flag_wr ? flag_wdata : (svc_clr ? 1'b0 : flag_ff))) :
        ~pin;
    assign flag = flag_ff;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_ff <= 1'b1;
            flag_ff   <= 1'b0;
        end else begin
            if (mc_tick) begin
                sample_ff <= pin;
            end
            flag_ff <= nxt_flag;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_EXT_LEVEL: assert property (!edge_mode |=> flag == !$past(pin))
        else $error("level flag not inverse of pin");
    AST_EXT_EDGE: assert property (edge_mode && fall |=> flag)
        else $error("falling edge did not set flag");
    AST_EXT_HOLD: assert property (
        edge_mode && flag && !flag_wr && !svc_clr |=> flag)
        else $error("edge flag dropped without clear");
endmodule : iep_extint

// file: hw/iep_arbiter.sv
/*
 * picks the pending source of highest level, lowest vector on ties.
 * assumes request vector already gated by enables; levels are used only where req is set.
 */
`timescale 1ns/1ps
module iep_arbiter (
    // requests
    input  wire logic [10:0] req,
    input  wire logic [21:0] lvl,
    // winner
    output logic             found,
    output logic [3:0]       best_vec,
    output logic [1:0]       best_lvl
);
    always_comb begin
        found    = 1'b0;
        best_vec = 4'h0;
        best_lvl = 2'h0;
        // downward scan with >= lets the lower vector win a tie
        for (int i = 10; i >= 0; i--) begin
            if (req[i] && (!found || lvl[2*i +: 2] >= best_lvl)) begin
                found    = 1'b1;
                best_vec = 4'(i);
                best_lvl = lvl[2*i +: 2];
            end
        end
    end
endmodule : iep_arbiter

// file: testbench/iep_core_model.sv
/*
 * core model: machine-cycle tick, acknowledge and service return.
 * assumes the bench sets ack_mode: 0 none, 1 prompt, 2 slow.
 */
`timescale 1ns/1ps
module iep_core_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // bench control
    input  wire logic [1:0] ack_mode,
    // interrupt handshake
    input  wire logic       irq_req,
    output logic            irq_ack,
    output logic            irq_return,
    output logic            mc_tick
);
    logic [2:0] wait_ff;

    initial irq_return = 1'b0;

    // machine cycle of two clocks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mc_tick <= 1'b0;
        end else begin
            mc_tick <= !mc_tick;
        end
    end

    // ack only while a request is offered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_ack <= 1'b0;
            wait_ff <= 3'h0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            wait_ff <= 3'h0;
        end else if (irq_req && ack_mode != 2'h0) begin
            if (ack_mode == 2'h1 || wait_ff == 3'h4) begin
                irq_ack <= 1'b1;
            end else begin
                wait_ff <= wait_ff + 3'h1;
            end
        end else begin
            wait_ff <= 3'h0;
        end
    end

    task automatic give_return;
        irq_return <= 1'b1;
        @(posedge clk);
        irq_return <= 1'b0;
    endtask : give_return
endmodule : iep_core_model

// file: testbench/tb_iep_irq_ctrl.sv
/*
 * self-checking bench of the interrupt enable and priority block.
 * assumes iep_core_model as core; peripheral flags driven here.
 */
`timescale 1ns/1ps
module tb_iep_irq_ctrl;
    logic       clk;
    logic       resetn;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic [7:0] core_en;
    logic       mc_tick;
    logic       irq_ack;
    logic       irq_return;
    logic       irq_req;
    logic [3:0] irq_vector;
    logic [1:0] irq_level;
    logic [3:0] pins;
    logic [1:0] tmr_set;
    logic       t2_flag;
    logic       ser_flag;
    logic [4:0] xflag;
    logic [1:0] tmr_run;
    logic [1:0] ack_mode;
    int         fails;
    int         compares;

    iep_irq_ctrl iep_irq_ctrl_i (.clk(clk), .resetn(resetn),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .core_irq_enable(core_en),
        .mc_tick(mc_tick), .irq_ack(irq_ack), .irq_return(irq_return),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
        .extint0_pin(pins[0]), .extint1_pin(pins[1]),
        .extint2_pin(pins[2]), .extint3_pin(pins[3]),
        .timer0_overflow_set(tmr_set[0]), .timer1_overflow_set(tmr_set[1]),
        .timer2_irq_flag(t2_flag), .serial_irq_flag(ser_flag),
        .brownout_detected_flag(xflag[4]),
        .wake_timer_overflow_flag(xflag[3]),
        .spi_transfer_done_flag(xflag[0]), .spi_overrun_flag(xflag[1]),
        .spi_mode_fault_flag(xflag[2]),
        .timer0_run(tmr_run[0]), .timer1_run(tmr_run[1]));

    iep_core_model iep_core_model_i (.clk(clk), .resetn(resetn),
        .ack_mode(ack_mode), .irq_req(irq_req), .irq_ack(irq_ack),
        .irq_return(irq_return), .mc_tick(mc_tick));

    always #4 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        check(sfr_rdata, exp);
    endtask : rchk

    task automatic wait_req(input logic [3:0] v, input logic [1:0] l);
        int n;
        repeat (3) @(posedge clk);
        #1;
        n = 0;
        while (irq_req !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({7'h0, irq_req}, 8'h01);
        check({4'h0, irq_vector}, {4'h0, v});
        check({6'h0, irq_level}, {6'h0, l});
    endtask : wait_req

    task automatic no_req;
        repeat (6) @(posedge clk);
        #1;
        check({7'h0, irq_req}, 8'h00);
    endtask : no_req

    task automatic do_ack(input logic [1:0] m);
        int n;
        @(posedge clk);
        ack_mode <= m;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq_ack !== 1'b1 && n < 30);
        ack_mode <= 2'h0;
        check({7'h0, irq_ack}, 8'h01);
    endtask : do_ack

    task automatic do_reset;
        @(posedge clk);
        resetn <= 1'b0;
        core_en <= 8'h00;
        pins <= 4'hf;
        {tmr_set, t2_flag, ser_flag, xflag, ack_mode} <= '0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
    endtask : do_reset

    task automatic t_regs;
        logic [7:0] adr [8] = '{8'h88, 8'hb8, 8'hba, 8'hbb, 8'hbc, 8'hbd,
                                8'hc0, 8'h90};
        logic [7:0] wd [8] = '{8'h55, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                               8'hdd, 8'hff};
        logic [7:0] ex [8] = '{8'h55, 8'h3f, 8'hff, 8'h07, 8'h07, 8'h07,
                               8'hdd, 8'h00};
        do_reset();
        foreach (adr[i]) rchk(adr[i], 8'h00);
        foreach (adr[i]) wr(adr[i], wd[i]);
        foreach (adr[i]) rchk(adr[i], ex[i]);
        check({6'h0, tmr_run}, 8'h03);
    endtask : t_regs

    task automatic t_ext(input int n);
        logic [7:0] ty;
        logic [7:0] fl;
        ty = 8'h01 << (2 * n);
        fl = 8'h02 << (2 * n);
        do_reset();
        core_en <= 8'h80 | ty;
        wr(8'h88, ty);
        @(posedge clk);
        pins[n] <= 1'b0;
        wait_req(4'(2 * n), 2'h0);
        rchk(8'h88, ty | fl);
        do_ack(2'h1);
        rchk(8'h88, ty);
        wr(8'h88, 8'h00);
        repeat (3) @(posedge clk);
        rchk(8'h88, fl);
        @(posedge clk);
        pins[n] <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(8'h88, 8'h00);
    endtask : t_ext

    task automatic t_x23(input int n);
        do_reset();
        core_en <= 8'h80;
        wr(8'hba, 8'h40 << n);
        wr(8'hc0, 8'h0d << (4 * n));
        @(posedge clk);
        pins[2 + n] <= 1'b0;
        wait_req(4'(6 + n), 2'h3);
        rchk(8'hc0, 8'h0f << (4 * n));
        do_ack(2'h1);
        rchk(8'hc0, 8'h0d << (4 * n));
    endtask : t_x23

    task automatic t_tmr(input int n);
        do_reset();
        core_en <= 8'h80 | (8'h02 << (2 * n));
        @(posedge clk);
        tmr_set[n] <= 1'b1;
        @(posedge clk);
        tmr_set[n] <= 1'b0;
        wait_req(4'(1 + 2 * n), 2'h0);
        rchk(8'h88, 8'h20 << (2 * n));
        do_ack(n == 0 ? 2'h1 : 2'h2);
        rchk(8'h88, 8'h00);
    endtask : t_tmr

    task automatic t_xsrc;
        int e;
        do_reset();
        core_en <= 8'h80;
        wr(8'hbc, 8'h05);
        wr(8'hbb, 8'h03);
        for (int k = 0; k < 5; k++) begin
            e = (k < 3) ? 0 : k - 2;
            @(posedge clk);
            xflag <= 5'h01 << k;
            no_req();
            wr(8'hbd, 8'h01 << e);
            wait_req(4'(8 + e), 2'(3 - e));
            wr(8'hbd, 8'h00);
            no_req();
        end
    endtask : t_xsrc

    task automatic t_prio;
        do_reset();
        core_en <= 8'hb0;
        @(posedge clk);
        ser_flag <= 1'b1;
        t2_flag <= 1'b1;
        wait_req(4'h4, 2'h0);
        wr(8'hb8, 8'h10);
        wait_req(4'h4, 2'h1);
        wr(8'hba, 8'h20);
        wait_req(4'h5, 2'h2);
        wr(8'hb8, 8'h30);
        wait_req(4'h5, 2'h3);
        do_ack(2'h1);
        no_req();
        @(posedge clk);
        iep_core_model_i.give_return();
        wait_req(4'h5, 2'h3);
        @(posedge clk);
        t2_flag <= 1'b0;
        wait_req(4'h4, 2'h1);
    endtask : t_prio

    task automatic t_swflag;
        do_reset();
        core_en <= 8'h83;
        wr(8'h88, 8'h01);
        wr(8'h88, 8'h23);
        wait_req(4'h0, 2'h0);
        rchk(8'h88, 8'h23);
        wr(8'h88, 8'h01);
        no_req();
        @(posedge clk);
        pins[0] <= 1'b0;
        sfr_wr <= 1'b1;
        sfr_addr <= 8'h88;
        sfr_wdata <= 8'h01;
        repeat (2) @(posedge clk);
        sfr_wr <= 1'b0;
        rchk(8'h88, 8'h03);
    endtask : t_swflag

    task automatic results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, core_en} = '0;
        {tmr_set, t2_flag, ser_flag, xflag, ack_mode} = '0;
        pins = 4'hf;
        fails = 0;
        compares = 0;
        do_reset();
        t_regs();
        for (int n = 0; n < 2; n++) begin
            t_ext(n);
            t_x23(n);
            t_tmr(n);
        end
        t_xsrc();
        t_prio();
        t_swflag();
        results();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end
endmodule : tb_iep_irq_ctrl
